// File: design/rcri_cfg.svh
// Offsets, field positions, reset values and constants of the reset-cause block
`ifndef RCRI_CFG_SVH
`define RCRI_CFG_SVH
`define RCRI_ADDR_W        12
`define RCRI_OFF_STATUS    12'h000
`define RCRI_OFF_STACK     12'h004
`define RCRI_OFF_RET_TOP   12'h008
`define RCRI_OFF_PC_LATCH  12'h00C
`define RCRI_OFF_PC        12'h010
`define RCRI_OFF_TBL_PTR   12'h014
`define RCRI_OFF_TBL_LATCH 12'h018
`define RCRI_OFF_INT_CTRL  12'h01C
`define RCRI_OFF_CONTROL   12'h020
`define RCRI_OFF_CAUSE     12'h024
`define RCRI_OFF_WORKING   12'h028
`define RCRI_OFF_PRODUCT   12'h02C
`define RCRI_OFF_INDIRECT  12'h030
`define RCRI_B_CM          5
`define RCRI_B_RI          4
`define RCRI_B_TO          3
`define RCRI_B_PD          2
`define RCRI_B_POR         1
`define RCRI_B_BOR         0
`define RCRI_B_HIGH_PRIO_GLOBAL_INT_ENABLE        7
`define RCRI_B_LOW_PRIO_GLOBAL_INT_ENABLE        6
`define RCRI_FLAGS_POR     6'h3C
`define RCRI_INTC1_RST     8'h00
`define RCRI_INTC2_RST     8'hFF
`define RCRI_INTC3_RST     8'hC0
`define RCRI_PC_W          21
`define RCRI_VEC_RESET     21'h000000
`define RCRI_VEC_HIGH      21'h000008
`define RCRI_VEC_LOW       21'h000018
`define RCRI_PC_STEP       21'h000002
`endif

// File: design/rcri_pkg.sv
// Types shared by the reset-cause block and its bench
package rcri_pkg;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } rcri_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } rcri_apb_rsp_t;

    // One-cycle event pulses from the core, same clock
    typedef struct packed {
        logic       por;
        logic       bor;
        logic       cfg_mismatch;
        logic       wdt;
        logic       rst_instr;
        logic       stk_full;
        logic       stk_unf;
        logic       int_wake;
        logic       int_high_prio;
        logic [7:0] int_bits;
    } rcri_evt_t;

    typedef enum logic [1:0] {
        RCRI_MODE_FULL = 2'h0,
        RCRI_MODE_RUN  = 2'h1,
        RCRI_MODE_IDLE = 2'h2
    } rcri_mode_t;

    typedef enum logic [13:0] {
        RCRI_C_NONE     = 14'h0001,
        RCRI_C_POR      = 14'h0002,
        RCRI_C_BOR      = 14'h0004,
        RCRI_C_CM       = 14'h0008,
        RCRI_C_MASTER_CLEAR_PIN_FUL = 14'h0010,
        RCRI_C_MASTER_CLEAR_PIN_RUN = 14'h0020,
        RCRI_C_MASTER_CLEAR_PIN_IDL = 14'h0040,
        RCRI_C_WDT_RST  = 14'h0080,
        RCRI_C_WDT_WAKE = 14'h0100,
        RCRI_C_RSTI     = 14'h0200,
        RCRI_C_STACK_FULL_FLAG   = 14'h0400,
        RCRI_C_STACK_UNDERFLOW_FLAG_R = 14'h0800,
        RCRI_C_STACK_UNDERFLOW_FLAG_E = 14'h1000,
        RCRI_C_INT_WAKE = 14'h2000
    } rcri_cause_t;
endpackage

// File: design/rcri_top.sv
// Reset-cause recording and core register initialisation with an APB register file
// Summary of operation
// R1: Unreset registers start unknown and keep contents across all other resets.
// R2: Watchdog wake-up resumes operation and leaves almost every register untouched.
// R3: Power-on: PC 0000h, set CM RI TO PD, clear POR BOR stack flags.
// R4: Brown-out: PC 0000h, set CM RI TO PD, clear BOR, keep rest.
// R5: Reset instruction: PC 0000h, clear only reset-instruction flag.
// R6: Master clear in run mode: PC 0000h, set watchdog-timeout flag.
// R7: Master clear in idle or sleep: set timeout flag, clear power-down flag.
// R8: Master clear at full power: PC 0000h, no flag changes.
// R9: Watchdog timeout at full power or run: PC 0000h, clear timeout flag.
// R10: Stack overflow with reset enable: PC 0000h, set stack-full flag.
// R11: Stack underflow with reset enable: PC 0000h, set stack-underflow flag.
// R12: Underflow without reset enable: no reset, still set stack-underflow flag.
// R13: Watchdog timeout in idle or sleep: wake at PC+2, clear TO and PD.
// R14: Interrupt wake from power-managed mode: PC+2, clear power-down flag.
// R15: Interrupt wake with global enable set loads the matching vector instead; a high-priority wake with only bit 6 set loads the low vector.
// R16: Resets clear return-stack top, PC latches, PC low and stack count.
// R17: Table pointer and latch cleared on resets; data registers untouched.
// R18: Resets load interrupt control 0000000x, FFh, C0h; wake sets causing bits.
// R19: Software rewrites power-on flag to one after each power-on.
// R20: Config mismatch resets and clears its flag; no other hardware event clears it.
// R21: Simultaneous sources: power-on first, then brown-out, then the others.
`timescale 1ns/1ps
`include "rcri_cfg.svh"

module rcri_top (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // APB slave
    input  wire rcri_pkg::rcri_apb_req_t i_apb,
    output rcri_pkg::rcri_apb_rsp_t      o_apb,
    // Core events and state
    input  wire rcri_pkg::rcri_evt_t    i_evt,
    input  wire rcri_pkg::rcri_mode_t   i_mode,
    input  wire logic [20:0]            i_core_pc,
    input  wire logic                   i_master_clear_pin_n,
    // Core control
    output logic                        o_core_reset,
    output logic                        o_pc_load,
    output logic [20:0]                 o_pc
);
    import rcri_pkg::*;

    logic [5:0]  flags;
    logic [5:0]  next_flags;
    logic        stack_full_flag;
    logic        stack_underflow_flag;
    logic [4:0]  stk_cnt;
    logic        next_full;
    logic        next_unf;
    logic [4:0]  next_cnt;
    logic [20:0] ret_top;
    logic [12:0] pc_latch;
    logic [21:0] tbl_ptr;
    logic [7:0]  table_latch;
    logic [7:0]  int_control_primary;
    logic [7:0]  int_control_second;
    logic [7:0]  int_control_third;
    logic        stack_error_reset_enable;
    rcri_cause_t cause;
    rcri_cause_t last_cause;
    logic [7:0]  working_register;
    logic [15:0] product;
    logic [11:0] indirect_ptr0;
    logic        master_clear_pin_s1;
    logic        master_clear_pin_s2;
    logic        master_clear_pin_s3;
    logic        master_clear_pin_low;
    logic        master_clear_pin_evt;
    logic        is_reset;
    logic        is_wake;
    logic        vec_hi;
    logic        vec_lo;
    logic        acc;
    logic        wr;
    logic [31:0] rd_data;
    logic        rd_err;

    // Pin filter: level changes only once the second and third stages agree
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            master_clear_pin_s1  <= 1'b1;
            master_clear_pin_s2  <= 1'b1;
            master_clear_pin_s3  <= 1'b1;
            master_clear_pin_low <= 1'b0;
        end else begin
            master_clear_pin_s1 <= i_master_clear_pin_n;
            master_clear_pin_s2 <= master_clear_pin_s1;
            master_clear_pin_s3 <= master_clear_pin_s2;
            if (master_clear_pin_s2 == master_clear_pin_s3) begin
                master_clear_pin_low <= ~master_clear_pin_s3;
            end
        end
    end
    assign master_clear_pin_evt = (master_clear_pin_s2 == master_clear_pin_s3) && ~master_clear_pin_s3 && ~master_clear_pin_low;

    // Source selection by fixed priority
    always_comb begin
        cause = RCRI_C_NONE;
        if (i_evt.por) begin
            cause = RCRI_C_POR; // R21
        end else if (i_evt.bor) begin
            cause = RCRI_C_BOR; // R21
        end else if (i_evt.cfg_mismatch) begin
            cause = RCRI_C_CM;
        end else if (master_clear_pin_evt) begin
            if (i_mode == RCRI_MODE_RUN) begin
                cause = RCRI_C_MASTER_CLEAR_PIN_RUN;
            end else if (i_mode == RCRI_MODE_IDLE) begin
                cause = RCRI_C_MASTER_CLEAR_PIN_IDL;
            end else begin
                cause = RCRI_C_MASTER_CLEAR_PIN_FUL;
            end
        end else if (i_evt.wdt) begin
            cause = (i_mode == RCRI_MODE_IDLE) ? RCRI_C_WDT_WAKE : RCRI_C_WDT_RST; // R13
        end else if (i_evt.rst_instr) begin
            cause = RCRI_C_RSTI;
        end else if (i_evt.stk_full && stack_error_reset_enable) begin
            cause = RCRI_C_STACK_FULL_FLAG; // R10
        end else if (i_evt.stk_unf) begin
            cause = stack_error_reset_enable ? RCRI_C_STACK_UNDERFLOW_FLAG_R : RCRI_C_STACK_UNDERFLOW_FLAG_E; // R11 R12
        end else if (i_evt.int_wake && (i_mode != RCRI_MODE_FULL)) begin
            cause = RCRI_C_INT_WAKE;
        end
    end

    assign is_reset = ~(cause inside {RCRI_C_NONE, RCRI_C_WDT_WAKE, RCRI_C_INT_WAKE, RCRI_C_STACK_UNDERFLOW_FLAG_E});
    assign is_wake  = (cause == RCRI_C_WDT_WAKE) || (cause == RCRI_C_INT_WAKE);
    assign vec_hi   = (cause == RCRI_C_INT_WAKE) && i_evt.int_high_prio && int_control_primary[`RCRI_B_HIGH_PRIO_GLOBAL_INT_ENABLE];
    assign vec_lo   = (cause == RCRI_C_INT_WAKE) && ~vec_hi && int_control_primary[`RCRI_B_LOW_PRIO_GLOBAL_INT_ENABLE];

    // APB: pready one cycle into the access phase, write lands at completion
    assign acc = i_apb.psel && i_apb.penable && o_apb.pready;
    assign wr  = acc && i_apb.pwrite && ~o_apb.pslverr;

    // Status flags: software write first, hardware event overrides it
    always_comb begin
        next_flags = flags;
        if (wr && (i_apb.paddr == `RCRI_OFF_STATUS)) begin
            next_flags = i_apb.pwdata[5:0]; // R19
        end
        unique case (cause)
            RCRI_C_POR: begin
                next_flags = `RCRI_FLAGS_POR; // R3
            end
            RCRI_C_BOR: begin
                next_flags[`RCRI_B_CM]  = 1'b1; // R4
                next_flags[`RCRI_B_RI]  = 1'b1;
                next_flags[`RCRI_B_TO]  = 1'b1;
                next_flags[`RCRI_B_PD]  = 1'b1;
                next_flags[`RCRI_B_BOR] = 1'b0;
            end
            RCRI_C_CM: begin
                next_flags[`RCRI_B_CM] = 1'b0; // R20
            end
            RCRI_C_MASTER_CLEAR_PIN_RUN: begin
                next_flags[`RCRI_B_TO] = 1'b1; // R6
            end
            RCRI_C_MASTER_CLEAR_PIN_IDL: begin
                next_flags[`RCRI_B_TO] = 1'b1; // R7
                next_flags[`RCRI_B_PD] = 1'b0;
            end
            RCRI_C_WDT_RST: begin
                next_flags[`RCRI_B_TO] = 1'b0; // R9
            end
            RCRI_C_WDT_WAKE: begin
                next_flags[`RCRI_B_TO] = 1'b0; // R13
                next_flags[`RCRI_B_PD] = 1'b0;
            end
            RCRI_C_RSTI: begin
                next_flags[`RCRI_B_RI] = 1'b0; // R5
            end
            RCRI_C_INT_WAKE: begin
                next_flags[`RCRI_B_PD] = 1'b0; // R14
            end
            RCRI_C_NONE, RCRI_C_MASTER_CLEAR_PIN_FUL, RCRI_C_STACK_FULL_FLAG, RCRI_C_STACK_UNDERFLOW_FLAG_R, RCRI_C_STACK_UNDERFLOW_FLAG_E: begin
                next_flags = next_flags; // R8
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            flags <= `RCRI_FLAGS_POR;
        end else begin
            flags <= next_flags;
        end
    end

    // Stack flags and count
    always_comb begin
        next_full = stack_full_flag;
        next_unf  = stack_underflow_flag;
        next_cnt  = stk_cnt;
        if (wr && (i_apb.paddr == `RCRI_OFF_STACK)) begin
            next_full = i_apb.pwdata[7];
            next_unf  = i_apb.pwdata[6];
            next_cnt  = i_apb.pwdata[4:0];
        end
        if (cause == RCRI_C_POR) begin
            next_full = 1'b0; // R3
            next_unf  = 1'b0;
        end
        if ((cause == RCRI_C_STACK_FULL_FLAG) || (i_evt.stk_full && ~stack_error_reset_enable)) begin
            next_full = 1'b1; // R10
        end
        if ((cause == RCRI_C_STACK_UNDERFLOW_FLAG_R) || (cause == RCRI_C_STACK_UNDERFLOW_FLAG_E)) begin
            next_unf = 1'b1; // R11 R12
        end
        if (is_reset) begin
            next_cnt = 5'h00; // R16
        end else if (vec_hi || vec_lo) begin
            next_cnt = 5'(stk_cnt + 5'h01); // R15
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stack_full_flag      <= 1'b0;
            stack_underflow_flag <= 1'b0;
            stk_cnt              <= 5'h00;
        end else begin
            stack_full_flag      <= next_full;
            stack_underflow_flag <= next_unf;
            stk_cnt              <= next_cnt;
        end
    end

    // Return-stack top and PC latches
    always_ff @(posedge i_clk) begin
        if (i_rst || is_reset) begin
            ret_top  <= 21'h000000; // R16
            pc_latch <= 13'h0000;
        end else begin
            if (vec_hi || vec_lo) begin
                ret_top <= i_core_pc; // R15
            end else if (wr && (i_apb.paddr == `RCRI_OFF_RET_TOP)) begin
                ret_top <= i_apb.pwdata[20:0];
            end
            if (wr && (i_apb.paddr == `RCRI_OFF_PC_LATCH)) begin
                pc_latch <= i_apb.pwdata[12:0];
            end
        end
    end

    // Program counter start value handed to the core
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pc         <= `RCRI_VEC_RESET;
            o_pc_load    <= 1'b1;
            o_core_reset <= 1'b1;
        end else begin
            o_core_reset <= is_reset;
            o_pc_load    <= is_reset || is_wake;
            if (is_reset) begin
                o_pc <= `RCRI_VEC_RESET; // R3 R4 R5 R16
            end else if (vec_hi) begin
                o_pc <= `RCRI_VEC_HIGH; // R15
            end else if (vec_lo) begin
                o_pc <= `RCRI_VEC_LOW; // R15
            end else if (is_wake) begin
                o_pc <= 21'(i_core_pc + `RCRI_PC_STEP); // R13 R14
            end else begin
                o_pc <= i_core_pc;
            end
        end
    end

    // Table pointer and latch; a wake leaves them alone
    always_ff @(posedge i_clk) begin
        if (i_rst || is_reset) begin
            tbl_ptr     <= 22'h000000; // R17
            table_latch <= 8'h00;
        end else begin
            if (wr && (i_apb.paddr == `RCRI_OFF_TBL_PTR)) begin
                tbl_ptr <= i_apb.pwdata[21:0];
            end
            if (wr && (i_apb.paddr == `RCRI_OFF_TBL_LATCH)) begin
                table_latch <= i_apb.pwdata[7:0];
            end
        end
    end

    // Interrupt control; bit 0 of the primary survives every reset event, only i_rst or a register write clears it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            int_control_primary <= `RCRI_INTC1_RST;
            int_control_second  <= `RCRI_INTC2_RST;
            int_control_third   <= `RCRI_INTC3_RST;
        end else if (is_reset) begin
            int_control_primary <= (`RCRI_INTC1_RST & 8'hFE) | {7'h00, int_control_primary[0]}; // R18
            int_control_second  <= `RCRI_INTC2_RST;
            int_control_third   <= `RCRI_INTC3_RST;
        end else begin
            if (wr && (i_apb.paddr == `RCRI_OFF_INT_CTRL)) begin
                int_control_primary <= i_apb.pwdata[7:0];
                int_control_second  <= i_apb.pwdata[15:8];
                int_control_third   <= i_apb.pwdata[23:16];
            end
            if (cause == RCRI_C_INT_WAKE) begin
                int_control_primary <= int_control_primary | i_evt.int_bits; // R18
            end
        end
    end

    // Control and cause capture
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            stack_error_reset_enable <= 1'b1;
            last_cause               <= RCRI_C_POR;
        end else begin
            if (wr && (i_apb.paddr == `RCRI_OFF_CONTROL)) begin
                stack_error_reset_enable <= i_apb.pwdata[0];
            end
            if (cause != RCRI_C_NONE) begin
                last_cause <= cause;
            end
        end
    end

    // Data registers with no reset: unknown at power-up, kept by any reset or wake
    always_ff @(posedge i_clk) begin
        if (wr && (i_apb.paddr == `RCRI_OFF_WORKING)) begin
            working_register <= i_apb.pwdata[7:0]; // R1 R2 R17
        end
        if (wr && (i_apb.paddr == `RCRI_OFF_PRODUCT)) begin
            product <= i_apb.pwdata[15:0];
        end
        if (wr && (i_apb.paddr == `RCRI_OFF_INDIRECT)) begin
            indirect_ptr0 <= i_apb.pwdata[11:0];
        end
    end

    always_comb begin
        rd_data = 32'h00000000;
        rd_err  = 1'b0;
        case (i_apb.paddr)
            `RCRI_OFF_STATUS:    rd_data = {26'h0000000, flags};
            `RCRI_OFF_STACK:     rd_data = {24'h000000, stack_full_flag, stack_underflow_flag, 1'b0, stk_cnt};
            `RCRI_OFF_RET_TOP:   rd_data = {11'h000, ret_top};
            `RCRI_OFF_PC_LATCH:  rd_data = {19'h00000, pc_latch};
            `RCRI_OFF_PC:        rd_data = {11'h000, o_pc};
            `RCRI_OFF_TBL_PTR:   rd_data = {10'h000, tbl_ptr};
            `RCRI_OFF_TBL_LATCH: rd_data = {24'h000000, table_latch};
            `RCRI_OFF_INT_CTRL:  rd_data = {8'h00, int_control_third, int_control_second, int_control_primary};
            `RCRI_OFF_CONTROL:   rd_data = {31'h00000000, stack_error_reset_enable};
            `RCRI_OFF_CAUSE:     rd_data = {18'h00000, last_cause};
            `RCRI_OFF_WORKING:   rd_data = {24'h000000, working_register};
            `RCRI_OFF_PRODUCT:   rd_data = {16'h0000, product};
            `RCRI_OFF_INDIRECT:  rd_data = {20'h00000, indirect_ptr0};
            default:             rd_err  = 1'b1;
        endcase
    end

    // Answer is registered so the read value is stable for the completing edge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_apb <= '0;
        end else if (i_apb.psel && i_apb.penable && ~o_apb.pready) begin
            o_apb.pready  <= 1'b1;
            o_apb.pslverr <= rd_err;
            o_apb.prdata  <= i_apb.pwrite ? 32'h00000000 : rd_data;
        end else begin
            o_apb <= '0;
        end
    end

    // Checks
    sequence s_por;
        i_evt.por;
    endsequence

    sequence s_wdt_idle;
        ~i_evt.por && ~i_evt.bor && ~i_evt.cfg_mismatch && ~master_clear_pin_evt && i_evt.wdt && (i_mode == RCRI_MODE_IDLE);
    endsequence

    AST_POR_FLAGS: assert property (@(posedge i_clk) disable iff (i_rst) // R3
        s_por |=> (flags == `RCRI_FLAGS_POR) && ~stack_full_flag && ~stack_underflow_flag && (o_pc == 21'h000000))
        else $error("power-on flags or PC wrong");

    AST_BOR_KEEP: assert property (@(posedge i_clk) disable iff (i_rst) // R4
        (cause == RCRI_C_BOR) |=> ~flags[`RCRI_B_BOR] && (flags[5:2] == 4'hF) && $stable(flags[`RCRI_B_POR]))
        else $error("brown-out flag update wrong");

    AST_RSTI_ONLY: assert property (@(posedge i_clk) disable iff (i_rst) // R5
        (cause == RCRI_C_RSTI) && ~wr |=> ~flags[`RCRI_B_RI] && (flags[3:0] == $past(flags[3:0])))
        else $error("reset instruction changed other flags");

    AST_MASTER_CLEAR_PIN_IDLE: assert property (@(posedge i_clk) disable iff (i_rst) // R7
        (cause == RCRI_C_MASTER_CLEAR_PIN_IDL) |=> flags[`RCRI_B_TO] && ~flags[`RCRI_B_PD] && o_core_reset)
        else $error("master clear in idle flags wrong");

    AST_WDT_WAKE: assert property (@(posedge i_clk) disable iff (i_rst) // R13
        s_wdt_idle |=> ~flags[`RCRI_B_TO] && ~flags[`RCRI_B_PD] && (o_pc == 21'($past(i_core_pc) + 21'h000002))
        && o_pc_load && ~o_core_reset)
        else $error("watchdog wake wrong");

    AST_UNF_NORESET: assert property (@(posedge i_clk) disable iff (i_rst) // R12
        (cause == RCRI_C_STACK_UNDERFLOW_FLAG_E) |=> stack_underflow_flag && ~o_core_reset && ~o_pc_load)
        else $error("underflow without enable misbehaved");

    AST_RESET_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst) // R16
        is_reset |=> (ret_top == 21'h000000) && (pc_latch == 13'h0000) && (stk_cnt == 5'h00) && (tbl_ptr == 22'h000000))
        else $error("reset did not clear core registers");

    AST_INTC_RESET: assert property (@(posedge i_clk) disable iff (i_rst) // R18
        is_reset |=> (int_control_second == 8'hFF) && (int_control_third == 8'hC0) && (int_control_primary[7:1] == 7'h00))
        else $error("interrupt control reset values wrong");

    AST_CM_ONLY: assert property (@(posedge i_clk) disable iff (i_rst) // R20
        $fell(flags[`RCRI_B_CM]) |-> ($past(cause) == RCRI_C_CM) || ($past(wr) && ($past(i_apb.paddr) == `RCRI_OFF_STATUS)))
        else $error("config mismatch flag cleared by another source");

    AST_VECTOR: assert property (@(posedge i_clk) disable iff (i_rst) // R15
        vec_hi |=> (o_pc == 21'h000008) && (stk_cnt == 5'($past(stk_cnt) + 5'h01)))
        else $error("high priority vector not loaded");
endmodule

// File: verification/test_reset_cause_and_register_init.sv
// Self-checking bench for the reset-cause and register-init block
`timescale 1ns/1ps
`include "rcri_cfg.svh"
module test_reset_cause_and_register_init;
    import rcri_pkg::*;
    logic          i_clk      = 1'b0;
    logic          i_rst      = 1'b1;
    rcri_apb_req_t req        = '0;
    rcri_apb_rsp_t o_apb;
    rcri_evt_t     evt        = '0;
    rcri_evt_t     ev;
    rcri_mode_t    mode       = RCRI_MODE_FULL;
    logic [20:0]   cpc        = 21'h000000;
    logic          master_clear_pin_n     = 1'b1;
    logic          o_core_reset;
    logic          o_pc_load;
    logic [20:0]   o_pc;
    int            err_count  = 0;
    int            n_compared = 0;
    logic [5:0]    mflags;
    logic [1:0]    mstk;
    logic [31:0]   lfsr       = 32'h00000002;
    logic [31:0]   tbl;

    always #4 i_clk = ~i_clk;

    rcri_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_apb(req), .o_apb(o_apb), .i_evt(evt), .i_mode(mode),
        .i_core_pc(cpc), .i_master_clear_pin_n(master_clear_pin_n), .o_core_reset(o_core_reset),
        .o_pc_load(o_pc_load), .o_pc(o_pc));

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic fail(input string s);
        err_count++;
        $display("MISMATCH at %0t: %s", $time, s);
    endtask

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) fail($sformatf("register read %h, expected %h", got, exp));
    endtask

    task automatic cmp_core(input logic [22:0] got, input logic [22:0] exp);
        n_compared++;
        if (got !== exp) fail($sformatf("core reset/load/pc %h, expected %h", got, exp));
    endtask

    // Entered just after a rising edge; answer taken at the edge that samples pready high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                       output logic err);
        int n;
        n = 0;
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge i_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_apb.pready !== 1'b1 && n < 20);
        if (n >= 20) fail("bus answer timed out");
        q = o_apb.prdata;
        err = o_apb.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
        // Idle edge so a following call never reassigns psel in this time step
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        err;
        apb(1'b1, a, d, q, err);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] q;
        logic        err;
        apb(1'b0, a, 32'h00000000, q, err);
        cmp_reg(q & m, exp);
        cmp_reg({31'h0, err}, 32'h00000000);
    endtask

    task automatic chk();
        rd(`RCRI_OFF_STATUS, {26'h0, mflags}, 32'h0000003F);
        rd(`RCRI_OFF_STACK, {24'h0, mstk, 6'h0}, 32'h000000C0);
        $display("step done at %0t, %0d compared", $time, n_compared);
    endtask

    // pk: -2 reset to zero, -1 wake at pc+2, -3 no load, otherwise the vector
    task automatic fire(input rcri_mode_t m, input int pk);
        logic [20:0] xp;
        lfsr = nxt(lfsr);
        xp = (pk == -1) ? {lfsr[20:1], 1'b0} + `RCRI_PC_STEP : (pk < 0) ? 21'h0 : pk[20:0];
        cpc  <= {lfsr[20:1], 1'b0};
        evt  <= ev;
        mode <= m;
        @(posedge i_clk);
        evt <= '0;
        @(negedge i_clk);
        cmp_core({o_core_reset, o_pc_load, o_pc & {21{pk != -3}}}, {pk == -2, pk != -3, xp});
        @(posedge i_clk);
        chk();
    endtask

    task automatic master_clear_pin(input rcri_mode_t m);
        int n;
        n = 0;
        mode   <= m;
        master_clear_pin_n <= 1'b0;
        do begin
            @(negedge i_clk);
            n++;
        end while (o_pc_load !== 1'b1 && n < 10);
        cmp_core({o_core_reset, o_pc_load, o_pc}, {2'b11, 21'h0});
        @(posedge i_clk);
        master_clear_pin_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        chk();
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        #40000;
        fail("watchdog expired");
        tally_and_finish();
    end

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        mflags = `RCRI_FLAGS_POR;
        mstk = 2'b00;
        chk();
        rd(`RCRI_OFF_INT_CTRL, 32'h00C0FF00, 32'hFFFFFFFF);
        wr(`RCRI_OFF_STATUS, 32'h0000003F);
        mflags = 6'h3F;
        tbl = nxt(lfsr) & 32'h003FFFFF;
        wr(`RCRI_OFF_WORKING, tbl);
        wr(`RCRI_OFF_TBL_PTR, tbl);
        ev = '0; ev.rst_instr = 1'b1; mflags[4] = 1'b0; fire(RCRI_MODE_FULL, -2);
        rd(`RCRI_OFF_TBL_PTR, 32'h0, 32'hFFFFFFFF);
        ev = '0; ev.bor = 1'b1; mflags = {4'hF, mflags[1], 1'b0}; fire(RCRI_MODE_FULL, -2);
        ev = '0; ev.cfg_mismatch = 1'b1; mflags[5] = 1'b0; fire(RCRI_MODE_FULL, -2);
        ev = '0; ev.wdt = 1'b1; mflags[3] = 1'b0; fire(RCRI_MODE_FULL, -2);
        mflags[3] = 1'b1; master_clear_pin(RCRI_MODE_RUN);
        ev = '0; ev.wdt = 1'b1; mflags[3] = 1'b0; fire(RCRI_MODE_RUN, -2);
        mflags[3] = 1'b1; mflags[2] = 1'b0; master_clear_pin(RCRI_MODE_IDLE);
        master_clear_pin(RCRI_MODE_FULL);
        wr(`RCRI_OFF_TBL_PTR, tbl);
        ev = '0; ev.wdt = 1'b1; mflags[3:2] = 2'b00; fire(RCRI_MODE_IDLE, -1);
        rd(`RCRI_OFF_TBL_PTR, tbl, 32'hFFFFFFFF);
        rd(`RCRI_OFF_CAUSE, {18'h0, RCRI_C_WDT_WAKE}, 32'hFFFFFFFF);
        ev = '0; ev.stk_full = 1'b1; mstk[1] = 1'b1; fire(RCRI_MODE_FULL, -2);
        ev = '0; ev.stk_unf = 1'b1; mstk[0] = 1'b1; fire(RCRI_MODE_FULL, -2);
        wr(`RCRI_OFF_STACK, 32'h0);
        wr(`RCRI_OFF_CONTROL, 32'h0);
        mstk = 2'b01; fire(RCRI_MODE_FULL, -3);
        wr(`RCRI_OFF_CONTROL, 32'h1);
        ev = '0; ev.int_wake = 1'b1; ev.int_bits = 8'h02;
        wr(`RCRI_OFF_STATUS, {26'h0, mflags | 6'h04});
        mflags[2] = 1'b0;
        wr(`RCRI_OFF_INT_CTRL, 32'h00C0FF00);
        fire(RCRI_MODE_IDLE, -1);
        rd(`RCRI_OFF_INT_CTRL, 32'h00C0FF02, 32'hFFFFFFFF);
        wr(`RCRI_OFF_INT_CTRL, 32'h00C0FF80);
        ev.int_high_prio = 1'b1; fire(RCRI_MODE_IDLE, 8);
        rd(`RCRI_OFF_RET_TOP, {11'h0, cpc}, 32'hFFFFFFFF);
        wr(`RCRI_OFF_INT_CTRL, 32'h00C0FF40);
        ev.int_high_prio = 1'b0; fire(RCRI_MODE_RUN, 24);
        rd(`RCRI_OFF_WORKING, tbl & 32'h000000FF, 32'hFFFFFFFF);
        ev = '0; ev.por = 1'b1; ev.bor = 1'b1; mflags = `RCRI_FLAGS_POR; mstk = 2'b00; fire(RCRI_MODE_FULL, -2);
        rd(`RCRI_OFF_INT_CTRL, 32'h00C0FF00, 32'hFFFFFFFE);
        rd(`RCRI_OFF_RET_TOP, 32'h0, 32'hFFFFFFFF);
        tally_and_finish();
    end
endmodule
